// ### rtl/oad_pkg.sv
package oad_pkg;
	// ==========================================================
	// Descriptor fields (bit 0 is most significant, as printed)
	localparam int OAD_DESC_W      = 12;
	localparam int OAD_WORD_W      = 36;
	localparam int OAD_ADDR_W      = 31;
	localparam int OAD_TAG_W       = 5;
	localparam int OAD_REG_W       = 7;
	localparam int OAD_SD_W        = 26;
	localparam int OAD_EWHI_W      = 5;
	localparam int OAD_FLD_W       = 6;
	localparam int OAD_MODE_W      = 5;
	localparam logic [OAD_MODE_W-1:0] OAD_MODE_LONG_VAR = 5'h02;
	localparam logic [OAD_FLD_W-1:0]  OAD_FLD_LONG_VAR  = 6'h00;
	// Singleword register 3 sits at quarterword address 12
	localparam logic [OAD_REG_W-1:0]  OAD_PC_REG        = 7'h0c;
	localparam int OAD_PR_MIN      = 3;
	localparam int OAD_SAO_SCALE   = 2;
	localparam int OAD_AR_SCALE    = 2;

	// ==========================================================
	// Operation kinds and precisions
	typedef enum logic [2:0]
	{
		OAD_OP_NONE     = 3'h0,
		OAD_OP_REG      = 3'h1,
		OAD_OP_MEM      = 3'h2,
		OAD_OP_MEM_IND  = 3'h3,
		OAD_OP_FAULT    = 3'h4,
		OAD_OP_ILLEGAL  = 3'h5
	} oad_op_e;

	typedef enum logic [1:0]
	{
		OAD_PREC_Q = 2'h0,
		OAD_PREC_H = 2'h1,
		OAD_PREC_S = 2'h2,
		OAD_PREC_D = 2'h3
	} oad_prec_e;

	typedef enum logic [2:0]
	{
		OAD_ST_IDLE  = 3'h0,
		OAD_ST_REGRD = 3'h1,
		OAD_ST_MEMRD = 3'h6,
		OAD_ST_DONE  = 3'h2,
		OAD_ST_ERR   = 3'h3
	} oad_state_e;

	typedef struct packed
	{
		logic [OAD_DESC_W-1:0] descriptor;
		logic [OAD_WORD_W-1:0] extended_word;
		oad_prec_e             prec;
		logic [OAD_TAG_W-1:0]  ring;
		logic [OAD_WORD_W-1:0] pc;
	} oad_req_s;

	typedef struct packed
	{
		oad_op_e               op;
		logic [OAD_REG_W-1:0]  reg_addr;
		logic [OAD_TAG_W-1:0]  tag;
		logic [OAD_ADDR_W-1:0] addr;
	} oad_rsp_s;
endpackage

// ### rtl/oad_decoder.sv
`timescale 1ns/1ps
// Behaviour
// RL1: Short register form addresses a quarterword among 128 register locations.
// RL2: Register 3 in short register form is register 3, not the program counter.
// RL3: Pseudoregister reads aligned register 12..124 (encoded /4) as base pointer.
// RL4: Pseudoregister offset held divided by 4, scaled by 4, range -128..124.
// RL5: Base pointer is a 5-bit tag above a 31-bit address.
// RL6: Register 3 used as base pointer yields the program counter.
// RL7: Operand segment follows the base pointer used for its address.
// RL8: First address term and indirect words are base pointers alike.
// RL9: Software keeps pointer, operand address and base register aligned.
// RL10: Fixed-base takes 31-bit address from extended word, tag is current ring.
// RL11: Fixed-base high field 4..7 direct; 2,3,8..11 indirect.
// RL12: Variable-base adds signed 26-bit displacement to aligned register address.
// RL13: Variable-base high field 20..23 direct; 24..27 indirect.
// RL14: Long operand address decoded wholly from the 36-bit extended word.
// RL15: Mode high four bits zero selects register form, low bit joins field.
// RL16: Extension flag set means an extended word accompanies the descriptor.
// RL17: Offsets add modulo 2^31, never carrying into the tag.
// RL18: Misaligned operand address raises alignment fault, no memory access.
module oad_decoder
	import oad_pkg::*;
(
	input  wire logic                  ref_clk,
	input  wire logic                  rst_n,
	input  wire logic                  req_valid,
	input  wire oad_req_s              req,
	output logic                       req_ready,
	output logic                       reg_rd_en,
	output logic [OAD_REG_W-1:0]       reg_rd_addr,
	input  wire logic [OAD_WORD_W-1:0] reg_rd_data,
	output logic                       mem_rd_en,
	output logic [OAD_TAG_W-1:0]       mem_rd_tag,
	output logic [OAD_ADDR_W-1:0]      mem_rd_addr,
	input  wire logic                  mem_rd_valid,
	input  wire logic [OAD_WORD_W-1:0] mem_rd_data,
	output logic                       rsp_valid,
	output oad_rsp_s                   rsp
);

	// ==========================================================
	// Reset synchroniser
	logic rst_meta_ff;
	logic rst_sync_ff;

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end
		else
		begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end

	// ==========================================================
	// Helpers
	// Modulo 2^31 add: the tag is carried separately, never touched
	function automatic logic [OAD_ADDR_W-1:0] add31(
		input logic [OAD_ADDR_W-1:0] base,
		input logic [OAD_ADDR_W-1:0] off
	);
		add31 = base + off; // [RL17]
	endfunction

	function automatic logic misaligned(
		input logic [OAD_ADDR_W-1:0] a,
		input oad_prec_e             p
	);
		logic [1:0] low;
		low = a[1:0];
		unique case (p)
			OAD_PREC_Q: misaligned = 1'b0;
			OAD_PREC_H: misaligned = low[0];
			OAD_PREC_S: misaligned = |low;
			OAD_PREC_D: misaligned = |low;
		endcase
	endfunction

	// Indirect words also pass here: bits 0..4 tag, 5..35 address [RL5] [RL8]
	function automatic logic [OAD_TAG_W-1:0] ptr_tag(input logic [OAD_WORD_W-1:0] w);
		ptr_tag = w[OAD_WORD_W-1 -: OAD_TAG_W];
	endfunction

	function automatic logic [OAD_ADDR_W-1:0] ptr_addr(input logic [OAD_WORD_W-1:0] w);
		ptr_addr = w[OAD_ADDR_W-1:0];
	endfunction

	// ==========================================================
	// Descriptor field split (printed bit 0 is our MSB)
	logic                  ext_flag;
	logic [OAD_MODE_W-1:0] mode_fld;
	logic [OAD_FLD_W-1:0]  low_fld;
	logic [OAD_EWHI_W-1:0] ew_hi;
	logic [OAD_REG_W-1:0]  pr_reg;
	logic [OAD_REG_W-1:0]  ar_reg;
	logic [OAD_ADDR_W-1:0] sao_ext;
	logic [OAD_ADDR_W-1:0] sd_ext;

	assign ext_flag = req.descriptor[11];
	assign mode_fld = req.descriptor[10:6];
	assign low_fld  = req.descriptor[5:0];
	assign ew_hi    = req.extended_word[35:31]; // [RL14]
	assign pr_reg   = {mode_fld, 2'b00}; // [RL3]
	assign ar_reg   = {req.extended_word[30:26], 2'b00}; // [RL12]
	assign sao_ext  = OAD_ADDR_W'({{(OAD_ADDR_W-8){low_fld[5]}}, low_fld, 2'b00}); // [RL4]
	assign sd_ext   = OAD_ADDR_W'({{(OAD_ADDR_W-OAD_SD_W){req.extended_word[25]}},
		req.extended_word[25:0]}); // [RL12]

	// ==========================================================
	// Control
	oad_state_e            state_ff;
	oad_prec_e             prec_ff;
	logic                  indir_ff;
	logic [OAD_ADDR_W-1:0] off_ff;
	logic [OAD_WORD_W-1:0] pc_ff;

	always_ff @(posedge ref_clk or negedge rst_sync_ff)
	begin
		if (!rst_sync_ff)
		begin
			state_ff    <= OAD_ST_IDLE;
			req_ready   <= 1'b0;
			reg_rd_en   <= 1'b0;
			reg_rd_addr <= '0;
			mem_rd_en   <= 1'b0;
			mem_rd_tag  <= '0;
			mem_rd_addr <= '0;
			rsp_valid   <= 1'b0;
			rsp         <= '0;
			prec_ff     <= OAD_PREC_Q;
			indir_ff    <= 1'b0;
			off_ff      <= '0;
			pc_ff       <= '0;
		end
		else
		begin
			reg_rd_en <= 1'b0;
			mem_rd_en <= 1'b0;
			rsp_valid <= 1'b0;
			unique case (state_ff)
				OAD_ST_IDLE:
				begin
					req_ready <= 1'b1;
					if (req_valid && req_ready)
					begin
						req_ready <= 1'b0;
						prec_ff   <= req.prec;
						pc_ff     <= req.pc;
						rsp       <= '0;
						if (!ext_flag && mode_fld[4:1] == 4'h0)
						begin
							// Register operand, R3 is itself here [RL1] [RL2] [RL15]
							rsp.op       <= misaligned(OAD_ADDR_W'({mode_fld[0], low_fld}),
								req.prec) ? OAD_OP_FAULT : OAD_OP_REG; // [RL18]
							rsp.reg_addr <= {mode_fld[0], low_fld};
							state_ff     <= OAD_ST_DONE;
						end
						else if (!ext_flag && int'(mode_fld) >= OAD_PR_MIN)
						begin
							reg_rd_en   <= 1'b1; // [RL3]
							reg_rd_addr <= pr_reg;
							off_ff      <= sao_ext;
							indir_ff    <= 1'b0;
							state_ff    <= OAD_ST_REGRD;
						end
						else if (ext_flag && mode_fld == OAD_MODE_LONG_VAR
							&& low_fld == OAD_FLD_LONG_VAR) // [RL16]
						begin
							if (ew_hi inside {[5'd2:5'd11]}) // [RL10] [RL11]
							begin
								rsp.tag  <= req.ring;
								rsp.addr <= req.extended_word[30:0];
								indir_ff <= !(ew_hi inside {[5'd4:5'd7]});
								if (!(ew_hi inside {[5'd4:5'd7]}))
								begin
									mem_rd_en   <= 1'b1;
									mem_rd_tag  <= req.ring;
									mem_rd_addr <= req.extended_word[30:0];
									state_ff    <= OAD_ST_MEMRD;
								end
								else
								begin
									rsp.op   <= misaligned(req.extended_word[30:0], req.prec)
										? OAD_OP_FAULT : OAD_OP_MEM; // [RL18]
									state_ff <= OAD_ST_DONE;
								end
							end
							else if (ew_hi inside {[5'd20:5'd27]}) // [RL12] [RL13]
							begin
								reg_rd_en   <= 1'b1;
								reg_rd_addr <= ar_reg;
								off_ff      <= sd_ext;
								indir_ff    <= ew_hi[3];
								state_ff    <= OAD_ST_REGRD;
							end
							else
							begin
								rsp.op   <= OAD_OP_ILLEGAL;
								state_ff <= OAD_ST_DONE;
							end
						end
						else
						begin
							// Constants and combined modes live elsewhere
							rsp.op   <= OAD_OP_ILLEGAL;
							state_ff <= OAD_ST_DONE;
						end
					end
				end
				OAD_ST_REGRD:
				begin
					// Base register: R3 reads as the program counter [RL6] [RL7]
					if (reg_rd_addr == OAD_PC_REG)
					begin
						rsp.tag  <= ptr_tag(pc_ff);
						rsp.addr <= add31(ptr_addr(pc_ff), off_ff);
					end
					else
					begin
						rsp.tag  <= ptr_tag(reg_rd_data);
						rsp.addr <= add31(ptr_addr(reg_rd_data), off_ff);
					end
					if (indir_ff)
					begin
						mem_rd_en   <= 1'b1; // [RL13]
						mem_rd_tag  <= (reg_rd_addr == OAD_PC_REG) ? ptr_tag(pc_ff)
							: ptr_tag(reg_rd_data);
						mem_rd_addr <= (reg_rd_addr == OAD_PC_REG)
							? add31(ptr_addr(pc_ff), off_ff)
							: add31(ptr_addr(reg_rd_data), off_ff);
						state_ff    <= OAD_ST_MEMRD;
					end
					else
					begin
						state_ff <= OAD_ST_ERR;
					end
				end
				OAD_ST_ERR:
				begin
					rsp.op   <= misaligned(rsp.addr, prec_ff) ? OAD_OP_FAULT : OAD_OP_MEM; // [RL18]
					state_ff <= OAD_ST_DONE;
				end
				OAD_ST_MEMRD:
				begin
					if (mem_rd_valid)
					begin
						// Fetched word becomes the new base pointer [RL8]
						rsp.tag  <= ptr_tag(mem_rd_data);
						rsp.addr <= ptr_addr(mem_rd_data);
						rsp.op   <= misaligned(ptr_addr(mem_rd_data), prec_ff)
							? OAD_OP_FAULT : OAD_OP_MEM_IND; // [RL18]
						state_ff <= OAD_ST_DONE;
					end
				end
				OAD_ST_DONE:
				begin
					rsp_valid <= 1'b1;
					state_ff  <= OAD_ST_IDLE;
				end
				default:
				begin
					state_ff <= OAD_ST_IDLE;
				end
			endcase
		end
	end

endmodule

// ### tb/oad_far_model.sv
`timescale 1ns/1ps
module oad_far_model
	import oad_pkg::*;
(
	input wire logic                  ref_clk,
	input wire logic [OAD_REG_W-1:0]  reg_rd_addr,
	output logic [OAD_WORD_W-1:0]     reg_rd_data,
	input wire logic                  mem_rd_en,
	input wire logic [OAD_ADDR_W-1:0] mem_rd_addr,
	input wire logic [3:0]            mem_lat,
	output logic                      mem_rd_valid = 1'b0,
	output logic [OAD_WORD_W-1:0]     mem_rd_data = '0
);
	logic [OAD_ADDR_W-1:0] a_ff;
	logic [3:0]            cnt_ff = 4'h0;
	// Near the top of the space, so offsets wrap
	assign reg_rd_data = {5'h0b, 31'h7fffff00 + 31'(reg_rd_addr)};
	always @(posedge ref_clk)
	begin
		cnt_ff <= mem_rd_en ? mem_lat : cnt_ff - 4'(cnt_ff != 4'h0);
		mem_rd_valid <= cnt_ff == 4'h1 && !mem_rd_en;
		// Stale data toggles, so every other cycle it repeats the last pointer
		mem_rd_data <= cnt_ff == 4'h1 ? {5'h0c, a_ff + 31'h40} : ~mem_rd_data;
		if (mem_rd_en)
			a_ff <= mem_rd_addr;
	end
endmodule

// ### tb/oad_props.sv
`timescale 1ns/1ps
module oad_props
	import oad_pkg::*;
(
	input wire logic                  ref_clk,
	input wire logic                  rst_n,
	input wire logic                  req_valid,
	input wire oad_req_s              req,
	input wire logic                  req_ready,
	input wire logic                  reg_rd_en,
	input wire logic [OAD_REG_W-1:0]  reg_rd_addr,
	input wire logic [OAD_WORD_W-1:0] reg_rd_data,
	input wire logic                  mem_rd_en,
	input wire logic [OAD_TAG_W-1:0]  mem_rd_tag,
	input wire logic [OAD_ADDR_W-1:0] mem_rd_addr,
	input wire logic                  rsp_valid,
	input wire oad_rsp_s              rsp
);
	oad_req_s              c_ff;
	logic [OAD_WORD_W-1:0] b_ff;
	logic [4:0]            hi;
	logic                  lng, sreg, psr;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	assign hi = c_ff.extended_word[35:31];
	assign lng = c_ff.descriptor == 12'h880;
	assign sreg = c_ff.descriptor[11:7] == 5'h00;
	// Mode 2 without extension is a short constant, not a pseudoregister
	assign psr = !c_ff.descriptor[11] && c_ff.descriptor[10:6] >= 5'h03;
	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n)
			c_ff <= '0;
		else if (req_valid && req_ready)
			c_ff <= req;
	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n)
			b_ff <= '0;
		else if (reg_rd_en)
			b_ff <= (reg_rd_addr == OAD_PC_REG) ? c_ff.pc : reg_rd_data;
	sequence s_take;
		req_valid && req_ready;
	endsequence
	a_reg_answer: assert property (s_take ##1 sreg |-> ##1 rsp_valid &&
		(rsp.op == OAD_OP_FAULT || rsp.op == OAD_OP_REG && rsp.reg_addr == c_ff.descriptor[6:0]))
		else $error("register answer wrong");
	a_reg_no_pc: assert property (rsp_valid && sreg && c_ff.prec == OAD_PREC_Q &&
		c_ff.descriptor[6:0] == OAD_PC_REG |-> rsp.op == OAD_OP_REG) else $error("r3 lost");
	a_pseudo_read: assert property (s_take ##1 psr |-> reg_rd_en &&
		reg_rd_addr == {c_ff.descriptor[10:6], 2'h0}) else $error("pseudo base read wrong");
	a_pseudo_addr: assert property (rsp_valid && psr && rsp.op == OAD_OP_MEM |->
		rsp.tag == b_ff[35:31] && rsp.addr == b_ff[30:0] +
		31'({{25{c_ff.descriptor[5]}}, c_ff.descriptor[5:0]} << 2)) else $error("pseudo addr");
	a_fix_direct: assert property (s_take ##1 lng && hi inside {[4:7]} |-> ##1
		rsp_valid && rsp.op == OAD_OP_MEM && rsp.tag == c_ff.ring &&
		rsp.addr == c_ff.extended_word[30:0]) else $error("fixed direct wrong");
	a_fix_fetch: assert property (s_take ##1 lng && hi inside {2, 3, [8:11]} |->
		##[0:1] mem_rd_en && mem_rd_tag == c_ff.ring && mem_rd_addr == c_ff.extended_word[30:0])
		else $error("fixed fetch wrong");
	a_var_read: assert property (s_take ##1 lng && hi inside {[20:27]} |-> ##[0:1]
		reg_rd_en && reg_rd_addr == {c_ff.extended_word[30:26], 2'h0}) else $error("var read");
	a_var_addr: assert property (rsp_valid && lng && hi inside {[20:23]} |->
		rsp.tag == b_ff[35:31] && rsp.addr == b_ff[30:0] +
		31'($signed(c_ff.extended_word[25:0]))) else $error("var addr wrong");
endmodule
bind oad_decoder oad_props oad_props_i (.ref_clk(ref_clk), .rst_n(rst_n), .req_valid(req_valid),
	.req(req), .req_ready(req_ready), .reg_rd_en(reg_rd_en), .reg_rd_addr(reg_rd_addr),
	.reg_rd_data(reg_rd_data), .mem_rd_en(mem_rd_en), .mem_rd_tag(mem_rd_tag),
	.mem_rd_addr(mem_rd_addr), .rsp_valid(rsp_valid), .rsp(rsp));

// ### tb/tb_oad_decoder.sv
`timescale 1ns/1ps
module tb_oad_decoder;
	import oad_pkg::*;
	logic                  ref_clk, rst_n, req_valid, req_ready, reg_rd_en;
	logic                  mem_rd_en, mem_rd_valid, rsp_valid;
	logic [OAD_REG_W-1:0]  reg_rd_addr;
	logic [OAD_WORD_W-1:0] reg_rd_data, mem_rd_data;
	logic [OAD_TAG_W-1:0]  mem_rd_tag;
	logic [OAD_ADDR_W-1:0] mem_rd_addr;
	logic [3:0]            mem_lat;
	oad_req_s              req;
	oad_rsp_s              rsp;
	int                    err_count, check_count;
	// Program counter as a base pointer, distinct from any register value
	localparam logic [35:0] TB_PC = {5'h09, 31'h00004000};
	oad_decoder oad_decoder_i (.ref_clk(ref_clk), .rst_n(rst_n), .req_valid(req_valid),
		.req(req), .req_ready(req_ready), .reg_rd_en(reg_rd_en), .reg_rd_addr(reg_rd_addr),
		.reg_rd_data(reg_rd_data), .mem_rd_en(mem_rd_en), .mem_rd_tag(mem_rd_tag),
		.mem_rd_addr(mem_rd_addr), .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data),
		.rsp_valid(rsp_valid), .rsp(rsp));
	oad_far_model oad_far_model_i (.ref_clk(ref_clk), .reg_rd_addr(reg_rd_addr),
		.reg_rd_data(reg_rd_data), .mem_rd_en(mem_rd_en), .mem_rd_addr(mem_rd_addr),
		.mem_lat(mem_lat), .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data));
	// ==========================================================
	// Shared tasks
	task automatic check(input logic [35:0] seen, input logic [35:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			err_count++;
			$display("ERROR %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	// Called at a falling edge; request held until the taking edge
	task automatic send(input logic [11:0] d, input logic [35:0] ew, input oad_prec_e p);
		int n;
		n = 0;
		req_valid = 1'b1;
		req = '{d, ew, p, 5'h06, TB_PC};
		while (req_ready !== 1'b1 && n++ < 60)
			@(negedge ref_clk);
		@(negedge ref_clk);
		req_valid = 1'b0;
		while (rsp_valid !== 1'b1 && n++ < 99)
			@(negedge ref_clk);
		check(36'(rsp_valid), 36'h1);
	endtask
	task automatic chk_mem(input oad_op_e op, input logic [4:0] tag, input logic [30:0] a);
		check(36'(rsp.op), 36'(op));
		check(36'(rsp.tag), 36'(tag));
		check(36'(rsp.addr), 36'(a));
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_reg_form();
		logic [6:0] r [4] = '{7'h0c, 7'h7f, 7'h08, 7'h0b};
		for (int i = 0; i < 4; i++)
		begin
			send({5'h00, r[i]}, 36'h0, i > 1 ? OAD_PREC_S : OAD_PREC_Q);
			check(36'(rsp.op), 36'(i == 3 ? OAD_OP_FAULT : OAD_OP_REG));
			if (i < 3)
				check(36'(rsp.reg_addr), 36'(r[i]));
		end
	endtask
	task automatic t_pseudo();
		logic [4:0] q [2] = '{5'h03, 5'h1f};
		logic [5:0] s [2] = '{6'h20, 6'h1f};
		logic [35:0] b;
		for (int i = 0; i < 2; i++)
		begin
			// Base register 3 reads as the program counter
			b = (q[i] == 5'h03) ? TB_PC : {5'h0b, 31'h7fffff00 + 31'({q[i], 2'h0})};
			send({1'b0, q[i], s[i]}, 36'h0, OAD_PREC_S);
			chk_mem(OAD_OP_MEM, b[35:31], b[30:0] +
				31'({{25{s[i][5]}}, s[i]} << 2));
		end
	endtask
	task automatic t_fixed();
		logic [30:0] la;
		for (int h = 0; h < 16; h++)
		begin
			la = 31'h00012340 + 31'(h * 16);
			mem_lat = h[0] ? 4'h5 : 4'h1;
			send(12'h880, {5'(h), la}, OAD_PREC_S);
			if (h inside {[4:7]})
				chk_mem(OAD_OP_MEM, 5'h06, la);
			else if (h inside {2, 3, [8:11]})
				chk_mem(OAD_OP_MEM_IND, 5'h0c, la + 31'h40);
			else
				check(36'(rsp.op), 36'(OAD_OP_ILLEGAL));
		end
	endtask
	task automatic t_var();
		logic [30:0] a;
		logic [25:0] sd;
		for (int h = 20; h < 28; h++)
		begin
			sd = h[0] ? 26'h0000200 : 26'h3fffff0;
			a = 31'h7fffff00 + 31'(h % 4 * 16) + 31'($signed(sd));
			mem_lat = h[1] ? 4'h3 : 4'h1;
			send(12'h880, {5'(h), 5'(h % 4 * 4), sd}, OAD_PREC_S);
			if (h < 24)
				chk_mem(OAD_OP_MEM, 5'h0b, a);
			else
				chk_mem(OAD_OP_MEM_IND, 5'h0c, a + 31'h40);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial
	begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	initial
	begin
		rst_n = 1'b0;
		req_valid = 1'b0;
		req = '0;
		mem_lat = 4'h1;
		repeat (10) @(negedge ref_clk);
		rst_n = 1'b1;
		t_reg_form();
		t_pseudo();
		t_fixed();
		t_var();
		complete_run();
	end
	initial
	begin
		repeat (5000) @(posedge ref_clk);
		err_count++;
		complete_run();
	end
endmodule
